// File: common/swis_defs.vh
`ifndef SWIS_DEFS_VH
`define SWIS_DEFS_VH

// interrupt and wake widths
`define SWIS_IRQ_W          480
`define SWIS_SENSE_W        483
`define SWIS_PRI_W          8
`define SWIS_EXC_W          9
`define SWIS_HINT_W         21
`define SWIS_WCFG_W         4

// wake_ctrl_cfg bit positions
`define SWIS_WCFG_EXTERNAL_WAKE_UNIT_PDN  3
`define SWIS_WCFG_EXTERNAL_WAKE_UNIT_PUP  2
`define SWIS_WCFG_USE_INTERNAL_WAKE_UNIT  1
`define SWIS_WCFG_WIC_SLEEP 0

// wake_source_mask bit positions
`define SWIS_SENSE_SYS_EVENT_IN     0
`define SWIS_SENSE_NMI      1
`define SWIS_SENSE_DBG      2
`define SWIS_SENSE_IRQ_LSB  3

// power_mode_hint fields
`define SWIS_HINT_RUN_BIT   0
`define SWIS_HINT_WAKE_BIT  1

// core states
`define SWIS_ST_RUN         2'h0
`define SWIS_ST_SLEEP       2'h1
`define SWIS_ST_HOLD        2'h2
`define SWIS_ST_LOCK        2'h3

`endif

// File: test/swis_monitor.sv
`timescale 1ns/100ps
module swis_monitor
(
	// clock and reset
	input wire        sys_clk,
	input wire        rst_b,
	// causes
	input wire        sleep_instr,
	input wire        send_event_instr,
	input wire        nmi_in,
	input wire        external_wake_event,
	input wire        hold_idle_req_n,
	// status
	input wire        low_power_ready,
	input wire        deep_low_power_ready,
	input wire        hold_idle_ack_n,
	input wire        core_run_enable,
	input wire        sys_event_out,
	input wire        lockup,
	input wire [20:0] power_mode_hint
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_running;
		core_run_enable && !lockup;
	endsequence
	sequence s_asleep;
		low_power_ready && !core_run_enable;
	endsequence
	chk_sleep_entry: assert property
		(sleep_instr ##0 s_running |=> s_asleep) else $error("no sleep");
	chk_deep_in_sleep: assert property
		(deep_low_power_ready |-> low_power_ready) else $error("deep awake");
	chk_hold_idle: assert property
		(!hold_idle_ack_n |-> s_asleep) else $error("ran in hold");
	chk_ack_release: assert property
		(hold_idle_req_n && !hold_idle_ack_n |=> hold_idle_ack_n)
		else $error("ack stuck");
	chk_nmi_wake: assert property
		(s_asleep ##0 (nmi_in && hold_idle_ack_n && hold_idle_req_n)
		|=> core_run_enable && !low_power_ready) else $error("no wake");
	chk_event_pulse: assert property
		(send_event_instr ##0 s_running ##1 !send_event_instr
		|-> sys_event_out ##1 !sys_event_out) else $error("bad pulse");
	chk_lockup_stays: assert property
		(lockup |=> lockup) else $error("left lockup");
	chk_hint_wake: assert property
		(external_wake_event |=> power_mode_hint[1]
		&& power_mode_hint[20:2] == 19'h0_0000) else $error("bad hint");
endmodule
bind swis_core_status swis_monitor swis_monitor_inst (.*);

// File: test/swis_partner.sv
`timescale 1ns/100ps
// power controller and external wake unit stand-in
module swis_partner
(
	// clock
	input wire  sys_clk,
	// core status
	input wire  low_power_ready,
	input wire  hold_idle_ack_n,
	// bench commands
	input wire  extend_req,
	input wire  wake_req,
	// to the core
	output reg  hold_idle_req_n = 1'b1,
	output reg  external_wake_event = 1'b0
);
	// sync drive, hold kept until released
	always @(posedge sys_clk)
	begin
		hold_idle_req_n <= !(extend_req && (low_power_ready | !hold_idle_ack_n));
		external_wake_event <= wake_req && low_power_ready && hold_idle_ack_n;
	end
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
	reg sys_clk = '0, rst_b = '0, sleep_instr = '0, sleep_on_deep = '0;
	reg send_event_instr = '0, lockup_entry = '0, handler_mode = '0;
	reg exc_fixed_priority = '0, nmi_in = '0, debug_halt_req = '0;
	reg sys_event_in = '0, extend_req = '0, wake_req = '0;
	reg [7:0] exc_priority = '0, base_priority_mask = '0;
	reg [8:0] program_status_exception_field = '0;
	reg [479:0] irq_in = '0;
	reg [3:0] wake_ctrl_cfg = '0;
	wire internal_wake_clk = sys_clk;
	wire internal_wake_rst_n = rst_b;
	wire hold_idle_req_n, external_wake_event, low_power_ready;
	wire deep_low_power_ready, hold_idle_ack_n, core_run_enable;
	wire sys_event_out, lockup, internal_wake_event;
	wire external_wake_unit_auto_pdn, external_wake_unit_auto_pup;
	wire [7:0] active_priority_level;
	wire [8:0] active_exception_number;
	wire [482:0] wake_source_mask;
	wire [20:0] power_mode_hint;
	integer errors = 0, n_compared = 0, i;
	swis_core_status #(.wake_line_count(10)) swis_core_status_inst (.*);
	swis_partner swis_partner_inst (.*);
	initial forever #2 sys_clk = ~sys_clk;
	// hang guard: tests need well under 100 cycles
	initial
	begin
		repeat (500) @(posedge sys_clk);
		errors = errors + 1;
		summarize;
	end
	task check(input string name, input [482:0] seen, input [482:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			errors = errors + 1;
			$display("unexpected %s exp %0h seen %0h", name, exp, seen);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task summarize;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task t_prio;
		program_status_exception_field = 9'h1a5;
		cyc(2);
		check("exc", active_exception_number, 9'h1a5);
		check("pri", active_priority_level, 8'h00);
		base_priority_mask = 8'h40;
		cyc(2);
		check("pri", active_priority_level, 8'h40);
		handler_mode = 1'b1;
		exc_priority = 8'hc0;
		cyc(2);
		check("pri", active_priority_level, 8'hc0);
		exc_fixed_priority = 1'b1;
		cyc(2);
		check("pri", active_priority_level, 8'h00);
		handler_mode = 1'b0;
		$display("prio done");
	endtask
	task t_hold;
		sleep_instr = 1'b1;
		extend_req = 1'b1;
		cyc(1);
		sleep_instr = 1'b0;
		check("sleep", low_power_ready, 1'b1);
		check("deep", deep_low_power_ready, 1'b0);
		cyc(2);
		check("ack", hold_idle_ack_n, 1'b0);
		nmi_in = 1'b1;
		cyc(3);
		check("run", core_run_enable, 1'b0);
		extend_req = 1'b0;
		cyc(2);
		check("ack", hold_idle_ack_n, 1'b1);
		cyc(1);
		nmi_in = 1'b0;
		check("run", core_run_enable, 1'b1);
		send_event_instr = 1'b1;
		cyc(1);
		send_event_instr = 1'b0;
		check("ev", sys_event_out, 1'b1);
		cyc(1);
		check("ev", sys_event_out, 1'b0);
		$display("hold done");
	endtask
	task t_wake;
		check("sense", wake_source_mask, 483'h3ff);
		wake_ctrl_cfg = 4'hf;
		sleep_on_deep = 1'b1;
		sleep_instr = 1'b1;
		cyc(1);
		check("deep", deep_low_power_ready, 1'b1);
		check("external_wake_unit", {external_wake_unit_auto_pdn, external_wake_unit_auto_pup}, 2'h3);
		irq_in[2] = 1'b1;
		sleep_instr = 1'b0;
		cyc(1);
		irq_in[2] = 1'b0;
		check("run", core_run_enable, 1'b1);
		for (i = 0; i < 8 && internal_wake_event !== 1'b1; i = i + 1)
			cyc(1);
		check("iwake", internal_wake_event, 1'b1);
		sleep_instr = 1'b1;
		wake_req = 1'b1;
		cyc(1);
		sleep_instr = 1'b0;
		cyc(2);
		wake_req = 1'b0;
		check("hint", power_mode_hint, 21'h0_0003);
		$display("wake done");
	endtask
	task t_src;
		for (i = 0; i < 2; i = i + 1)
		begin
			sleep_instr = 1'b1;
			cyc(1);
			sleep_instr = 1'b0;
			check("run", core_run_enable, 1'b0);
			debug_halt_req = (i == 0);
			sys_event_in = (i == 1);
			cyc(1);
			{debug_halt_req, sys_event_in} = 2'h0;
			check("run", core_run_enable, 1'b1);
		end
		$display("sources done");
	endtask
	task t_lock;
		lockup_entry = 1'b1;
		cyc(1);
		lockup_entry = 1'b0;
		send_event_instr = 1'b1;
		cyc(3);
		send_event_instr = 1'b0;
		check("lock", lockup, 1'b1);
		check("ev", sys_event_out, 1'b0);
		$display("lock done");
	endtask
	initial
	begin
		cyc(3);
		rst_b = 1'b1;
		cyc(3);
		t_prio;
		t_hold;
		t_wake;
		t_src;
		cyc(3);
		t_lock;
		summarize;
	end
endmodule

// File: verilog/swis_core_status.v
`timescale 1ns/100ps
`include "swis_defs.vh"

// Function
// - low_power_ready high when ready to sleep, low when running or waking
// - deep_low_power_ready only ever high together with low_power_ready
// - no fetch while hold_idle_ack_n low, until hold request returns high
// - hold ack low stops execution and memory operations
// - once hold acknowledged, core stays idle despite wake events
// - interrupts active high, pulse and level treated alike
// - interrupt vector 480 wide, intr_count_param lines implemented
// - handler mode configurable priority drives programmed level
// - handler mode negative priority drives zero
// - thread mode drives base_priority_mask, zero when mask zero
// - active_exception_number is low nine bits of exception field
// - wake_ctrl_cfg bits: external_wake_unit powerdown, powerup, use internal, wic sleep
// - internal wake unit has its own clock and active low reset
// - internal wake unit raises wake on event during wic sleep
// - wake_source_mask 483 wide, bits above wake_line_count low
// - mask bit0 event, bit1 nmi, bit2 debug, bits3 up irqs
// - external_wake_event reflected onto power_mode_hint
// - one cycle sys_event_out per send event in run state, none in sleep, hold or lockup; sys_event_in wakes
// - lockup output high while in lockup state
// - power_mode_hint is 21 bit minimum power mode indication
module swis_core_status
#(
	parameter intr_count_param = 480,
	parameter wake_line_count  = 483
)
(
	// clock and reset
	input  wire                     sys_clk,
	input  wire                     rst_b,
	input  wire                     internal_wake_clk,
	input  wire                     internal_wake_rst_n,
	// core execution state
	input  wire                     sleep_instr,
	input  wire                     sleep_on_deep,
	input  wire                     send_event_instr,
	input  wire                     lockup_entry,
	input  wire                     handler_mode,
	input  wire                     exc_fixed_priority,
	input  wire [`SWIS_PRI_W-1:0]   exc_priority,
	input  wire [`SWIS_PRI_W-1:0]   base_priority_mask,
	input  wire [`SWIS_EXC_W-1:0]   program_status_exception_field,
	// interrupt and event inputs
	input  wire [`SWIS_IRQ_W-1:0]   irq_in,
	input  wire                     nmi_in,
	input  wire                     debug_halt_req,
	input  wire                     sys_event_in,
	// wake controller
	input  wire [`SWIS_WCFG_W-1:0]  wake_ctrl_cfg,
	input  wire                     external_wake_event,
	// hold handshake
	input  wire                     hold_idle_req_n,
	// status outputs
	output reg                      low_power_ready,
	output reg                      deep_low_power_ready,
	output reg                      hold_idle_ack_n,
	output reg                      core_run_enable,
	output reg  [`SWIS_PRI_W-1:0]   active_priority_level,
	output reg  [`SWIS_EXC_W-1:0]   active_exception_number,
	output reg                      sys_event_out,
	output reg                      lockup,
	output reg  [`SWIS_SENSE_W-1:0] wake_source_mask,
	output reg  [`SWIS_HINT_W-1:0]  power_mode_hint,
	output reg                      internal_wake_event,
	output reg                      external_wake_unit_auto_pdn,
	output reg                      external_wake_unit_auto_pup
);

	localparam ST_RUN   = `SWIS_ST_RUN;
	localparam ST_SLEEP = `SWIS_ST_SLEEP;
	localparam ST_HOLD  = `SWIS_ST_HOLD;
	localparam ST_LOCK  = `SWIS_ST_LOCK;

	// lanes above the configured count are forced low
	function [`SWIS_SENSE_W-1:0] swis_lane_mask;
		input integer count;
		integer i;
		begin
			for (i = 0; i < `SWIS_SENSE_W; i = i + 1)
				swis_lane_mask[i] = (i < count);
		end
	endfunction

	// sleep and held sleep both count as asleep for status and wake
	function swis_asleep;
		input [1:0] st;
		begin
			swis_asleep = (st == ST_SLEEP) || (st == ST_HOLD);
		end
	endfunction

	localparam [`SWIS_SENSE_W-1:0] SENSE_LIVE =
		swis_lane_mask(wake_line_count);
	localparam [`SWIS_SENSE_W-1:0] IRQ_LIVE =
		swis_lane_mask(intr_count_param + `SWIS_SENSE_IRQ_LSB);

	reg                      rst_s1_reg;
	reg                      rst_s2_reg;
	reg [1:0]                state_reg;
	reg [1:0]                state_next;
	reg                      deep_reg;
	reg                      iw_s1_reg;
	reg                      wake_arm_reg;
	reg [`SWIS_SENSE_W-1:0]  sources_reg;
	reg [`SWIS_HINT_W-1:0]   hint_next;
	reg [`SWIS_SENSE_W-1:0]  sources;
	wire                     rst_n;
	wire                     wake_any;
	wire                     wic_sleep;
	wire                     iw_event;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	// assert at once, release on a clock edge so no flop sees a runt edge
	assign rst_n = rst_s2_reg;

	// ------------------------------------------------------------
	// wake sources
	// ------------------------------------------------------------
	// source lane order
	always @*
	begin
		sources = {irq_in, debug_halt_req, nmi_in, sys_event_in};
		sources = sources & IRQ_LIVE;
	end

	// inputs already synchronous, no resync stage
	assign wake_any  = |sources;
	// wic sleep only in deep sleep with bit 0 set
	assign wic_sleep = swis_asleep(state_reg) && deep_reg &&
		wake_ctrl_cfg[`SWIS_WCFG_WIC_SLEEP];

	// ------------------------------------------------------------
	// wake unit feed
	// ------------------------------------------------------------
	// only flop outputs reach the other clock domain; arm and sources
	// move on the same edge so the wake unit sees them aligned
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_arm_reg <= 1'b0;
			sources_reg  <= {`SWIS_SENSE_W{1'b0}};
		end
		else
		begin
			wake_arm_reg <= wic_sleep &
				wake_ctrl_cfg[`SWIS_WCFG_USE_INTERNAL_WAKE_UNIT];
			sources_reg  <= sources;
		end
	end

	// internal unit armed only when bit 1 is set during wic sleep
	swis_wake_unit u_wake
	(
		.internal_wake_clk   (internal_wake_clk),
		.internal_wake_rst_n (internal_wake_rst_n),
		.wic_sleep           (wake_arm_reg),
		.wake_sources        (sources_reg),
		.wake_source_mask    (wake_source_mask),
		.internal_wake_event (iw_event)
	);

	// ------------------------------------------------------------
	// sleep and hold state machine
	// ------------------------------------------------------------
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN:
				if (lockup_entry)
					state_next = ST_LOCK;
				else if (sleep_instr)
					state_next = ST_SLEEP;
			ST_SLEEP:
				if (!hold_idle_req_n)
					state_next = ST_HOLD;
				else if (wake_any || external_wake_event)
					state_next = ST_RUN;
			ST_HOLD:
				if (hold_idle_req_n)
					state_next = ST_SLEEP;
			ST_LOCK:
				state_next = ST_LOCK;
			default:
				state_next = ST_RUN;
		endcase
	end

	// ------------------------------------------------------------
	// power mode hint
	// ------------------------------------------------------------
	// only the run and wake bits are used; the rest stay low so the
	// power controller never reads a mode the core did not ask for
	always @*
	begin
		hint_next = {`SWIS_HINT_W{1'b0}};
		hint_next[`SWIS_HINT_RUN_BIT]  = (state_next == ST_RUN);
		hint_next[`SWIS_HINT_WAKE_BIT] = external_wake_event;
	end

	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg            <= ST_RUN;
			deep_reg             <= 1'b0;
			low_power_ready      <= 1'b0;
			deep_low_power_ready <= 1'b0;
			hold_idle_ack_n      <= 1'b1;
			core_run_enable      <= 1'b0;
			sys_event_out        <= 1'b0;
			lockup               <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg == ST_RUN && sleep_instr)
				deep_reg <= sleep_on_deep;
			low_power_ready <= swis_asleep(state_next);
			deep_low_power_ready <= swis_asleep(state_next) &&
				((state_reg == ST_RUN) ? sleep_on_deep : deep_reg);
			hold_idle_ack_n <= (state_next != ST_HOLD);
			core_run_enable <= (state_next == ST_RUN);
			sys_event_out <= send_event_instr &&
				(state_reg == ST_RUN);
			lockup <= (state_next == ST_LOCK);
		end
	end

	// ------------------------------------------------------------
	// priority and exception number
	// ------------------------------------------------------------
	// tracks its inputs in every state, so a held core still
	// reports the level and number it stopped at
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_priority_level   <= 8'h00;
			active_exception_number <= 9'h000;
		end
		else
		begin
			if (handler_mode)
				active_priority_level <= exc_fixed_priority ?
					8'h00 : exc_priority;
			else
				active_priority_level <= base_priority_mask;
			active_exception_number <=
				program_status_exception_field;
		end
	end

	// ------------------------------------------------------------
	// wake controller outputs
	// ------------------------------------------------------------
	// the wake result crosses back through two flops; limitation: the
	// wake clock must not outrun sys_clk or its pulse can slip past
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_source_mask    <= {`SWIS_SENSE_W{1'b0}};
			power_mode_hint     <= {`SWIS_HINT_W{1'b0}};
			iw_s1_reg           <= 1'b0;
			internal_wake_event <= 1'b0;
			external_wake_unit_auto_pdn       <= 1'b0;
			external_wake_unit_auto_pup       <= 1'b0;
		end
		else
		begin
			wake_source_mask <= SENSE_LIVE & IRQ_LIVE;
			power_mode_hint <= hint_next;
			iw_s1_reg           <= iw_event;
			internal_wake_event <= iw_s1_reg;
			external_wake_unit_auto_pdn <= wake_ctrl_cfg[`SWIS_WCFG_EXTERNAL_WAKE_UNIT_PDN];
			external_wake_unit_auto_pup <= wake_ctrl_cfg[`SWIS_WCFG_EXTERNAL_WAKE_UNIT_PUP];
		end
	end

endmodule

// File: verilog/swis_wake_unit.v
`timescale 1ns/100ps
`include "swis_defs.vh"

// internal wake unit: own clock and reset domain
module swis_wake_unit
(
	// clock and reset
	input  wire                     internal_wake_clk,
	input  wire                     internal_wake_rst_n,
	// status from the core domain
	input  wire                     wic_sleep,
	input  wire [`SWIS_SENSE_W-1:0] wake_sources,
	input  wire [`SWIS_SENSE_W-1:0] wake_source_mask,
	// wake result
	output reg                      internal_wake_event
);

	reg sleep_s1_reg;
	reg sleep_s2_reg;
	reg hit_s1_reg;
	reg hit_s2_reg;

	// ------------------------------------------------------------
	// crossing and detection
	// ------------------------------------------------------------
	// own clock and reset
	always @(posedge internal_wake_clk or negedge internal_wake_rst_n)
	begin
		if (!internal_wake_rst_n)
		begin
			sleep_s1_reg        <= 1'b0;
			sleep_s2_reg        <= 1'b0;
			hit_s1_reg          <= 1'b0;
			hit_s2_reg          <= 1'b0;
			internal_wake_event <= 1'b0;
		end
		else
		begin
			sleep_s1_reg        <= wic_sleep;
			sleep_s2_reg        <= sleep_s1_reg;
			hit_s1_reg          <= |(wake_sources & wake_source_mask);
			hit_s2_reg          <= hit_s1_reg;
			internal_wake_event <= sleep_s2_reg & hit_s2_reg;
		end
	end

endmodule
